/* File: spc_consts.svh */
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
// Register offsets on the byte-wide register port
`define SPC_OFS_HOST_ADDR   8'h22
`define SPC_OFS_CTRL        8'h23
`define SPC_OFS_WFLAG0      8'h24
`define SPC_OFS_WFLAG3      8'h27
`define SPC_OFS_RFLAG0      8'h28
`define SPC_OFS_RFLAG3      8'h2b
// Reset values
`define SPC_RST_HOST_ADDR   7'h4c
`define SPC_RST_CTRL        8'h00
// Control register field positions
`define SPC_BIT_PORT_ON     7
`define SPC_BIT_SELECT      6
`define SPC_BIT_ACTIVE      5
`define SPC_BIT_STOP_EN     4
`define SPC_BIT_RD_IRQ      3
`define SPC_BIT_WR_IRQ      2
`define SPC_TRIG_HI         1
`define SPC_TRIG_LO         0
// Trigger codes
`define SPC_TRIG_XFER       2'h0
`define SPC_TRIG_MB15       2'h1
`define SPC_TRIG_MB31       2'h2
`define SPC_MB15            5'h0f
`define SPC_MB31            5'h1f
// Last count of the boot wait; the boot step waits this many cycles plus one for the chip-select synchroniser
`define SPC_BOOT_WAIT       2'h3
`endif

/* File: spc_host_model.sv */
`timescale 1ns/100ps
module spc_host_model
	import spc_pkg::*;
(
	// Clock
	input  wire logic  MCLK,
	// Engine events and pins
	output spc_mb_evt_t MB_EVT,
	output logic        I2C_AWAKE,
	output logic        CHIP_SELECT_N
);
	initial begin
		MB_EVT = '0;
		I2C_AWAKE = 1'b0;
		CHIP_SELECT_N = 1'b1;
	end
	// Pins move right after an edge so the synchroniser sees a clean level
	task automatic pins(input logic aw, input logic cs);
		@(posedge MCLK);
		I2C_AWAKE <= aw;
		CHIP_SELECT_N <= cs;
	endtask
	// One host access pulse; last marks the end of the host transfer
	task automatic access(input logic w, input logic r, input logic [4:0] i, input logic last);
		@(posedge MCLK);
		MB_EVT <= '{w, r, i, last};
		@(posedge MCLK);
		MB_EVT <= '0;
	endtask
endmodule

/* File: spc_pkg.sv */
package spc_pkg;
	// One host access to a mailbox byte, reported by the port engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] idx;
		logic       xfer_end;
	} spc_mb_evt_t;

	// Control and status settings held by the block
	typedef struct packed {
		logic       port_on;
		logic       select_spi;
		logic       stop_en;
		logic       rd_irq_allow;
		logic       wr_irq_allow;
		logic [1:0] trig;
	} spc_ctrl_t;

	typedef enum logic [1:0] {
		BOOT_WAIT,
		BOOT_LOAD,
		BOOT_RUN
	} spc_boot_t;
endpackage

/* File: spc_port_ctrl.sv */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "spc_consts.svh"

module spc_port_ctrl
	import spc_pkg::*;
#(
	parameter bit HAS_I2C = 1'b1,
	parameter bit HAS_SPI = 1'b1
) (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RESET,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	// Port engine and pins
	input  spc_mb_evt_t      MB_EVT,
	input  wire logic        I2C_AWAKE,
	input  wire logic        CHIP_SELECT_N,
	input  wire logic        STOP_MODE,
	// Port configuration and interrupt
	output logic             PORT_ON,
	output logic             IFACE_SPI,
	output logic      [6:0]  HOST_ADDR,
	output logic             CPU_IRQ
);

	spc_ctrl_t   ctrl_q;
	spc_boot_t   boot_q;
	logic [1:0]  boot_cnt_q;
	logic [6:0]  addr_q;
	logic [31:0] wflags_q;
	logic [31:0] rflags_q;
	logic        cs_meta_q;
	logic        cs_sync_q;
	logic        pend_w_q;
	logic        pend_r_q;
	logic        seen_w_q;
	logic        seen_r_q;
	logic        wr_addr;
	logic        wr_ctrl;
	logic        flag_clear_strobe;
	logic        active;
	logic        fire_w;
	logic        fire_r;
	logic        mb_wr;
	logic        mb_rd;

	// Byte n of a 32-bit flag set, byte 0 holding mailboxes 31..24
	function automatic logic [7:0] flag_byte(input logic [31:0] f, input logic [1:0] n);
		logic [7:0] b;
		b = f[8*(3-n) +: 8];
		return b;
	endfunction

	// Trigger match for one access under the selected code
	function automatic logic trig_hit(input logic [1:0] t, input logic [4:0] idx);
		logic h;
		h = ((t == `SPC_TRIG_MB15) && (idx == `SPC_MB15)) ||
		    ((t == `SPC_TRIG_MB31) && (idx == `SPC_MB31));
		return h;
	endfunction

	assign wr_addr = REG_WR && (REG_ADDR == `SPC_OFS_HOST_ADDR);
	assign wr_ctrl = REG_WR && (REG_ADDR == `SPC_OFS_CTRL);
	assign flag_clear_strobe = wr_ctrl && REG_WDATA[`SPC_BIT_ACTIVE];
	// Accesses only count while the port is on
	assign mb_wr = MB_EVT.wr && ctrl_q.port_on;
	assign mb_rd = MB_EVT.rd && ctrl_q.port_on;

	assign active = ctrl_q.select_spi ? !cs_sync_q : I2C_AWAKE;

	// Chip-select is a pin; idle high so reset to one
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
		end else begin
			cs_meta_q <= CHIP_SELECT_N;
			cs_sync_q <= cs_meta_q;
		end
	end

	// Boot step: waits for the synchroniser, then loads port settings once
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			boot_q     <= BOOT_WAIT;
			boot_cnt_q <= 2'h0;
		end else begin
			case (boot_q)
				BOOT_WAIT: begin
					boot_cnt_q <= boot_cnt_q + 2'h1;
					if (boot_cnt_q == `SPC_BOOT_WAIT) begin
						boot_q <= BOOT_LOAD;
					end
				end
				BOOT_LOAD: begin
					boot_q <= BOOT_RUN;
				end
				default: begin
					boot_q <= BOOT_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			addr_q <= `SPC_RST_HOST_ADDR;
		end else if (wr_addr) begin
			addr_q <= REG_WDATA[6:0];
		end
	end

	// Control register; boot load takes priority over a software write
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ctrl_q <= '0;
		end else if (boot_q == BOOT_LOAD) begin
			ctrl_q.port_on <= 1'b1;
			if (HAS_I2C && HAS_SPI) begin
				ctrl_q.select_spi <= !cs_sync_q;
			end else begin
				ctrl_q.select_spi <= !HAS_I2C;
			end
		end else if (wr_ctrl) begin
			if (HAS_I2C && HAS_SPI) begin
				ctrl_q.port_on    <= REG_WDATA[`SPC_BIT_PORT_ON];
				ctrl_q.select_spi <= REG_WDATA[`SPC_BIT_SELECT];
			end
			ctrl_q.stop_en      <= REG_WDATA[`SPC_BIT_STOP_EN];
			ctrl_q.rd_irq_allow <= REG_WDATA[`SPC_BIT_RD_IRQ];
			ctrl_q.wr_irq_allow <= REG_WDATA[`SPC_BIT_WR_IRQ];
			ctrl_q.trig         <= REG_WDATA[`SPC_TRIG_HI:`SPC_TRIG_LO];
		end
	end

	// flag setting; a new access wins over the clear strobe
	generate
		for (genvar i = 0; i < 32; i++) begin : g_flag
			always_ff @(posedge MCLK or posedge RESET) begin
				if (RESET) begin
					wflags_q[i] <= 1'b0;
					rflags_q[i] <= 1'b0;
				end else begin
					if (mb_wr && (MB_EVT.idx == 5'(i))) begin
						wflags_q[i] <= 1'b1;
					end else if (flag_clear_strobe) begin
						wflags_q[i] <= 1'b0;
					end
					if (mb_rd && (MB_EVT.idx == 5'(i))) begin
						rflags_q[i] <= 1'b1;
					end else if (flag_clear_strobe) begin
						rflags_q[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// transfer-level tracking for code 00; one interrupt per transfer
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			seen_w_q <= 1'b0;
			seen_r_q <= 1'b0;
		end else if (MB_EVT.xfer_end) begin
			seen_w_q <= 1'b0;
			seen_r_q <= 1'b0;
		end else begin
			if (mb_wr) begin
				seen_w_q <= 1'b1;
			end
			if (mb_rd) begin
				seen_r_q <= 1'b1;
			end
		end
	end

	// trigger only when allowed; code 11 never fires
	always_comb begin
		fire_w = 1'b0;
		fire_r = 1'b0;
		if (ctrl_q.trig == `SPC_TRIG_XFER) begin
			fire_w = MB_EVT.xfer_end && (seen_w_q || mb_wr);
			fire_r = MB_EVT.xfer_end && (seen_r_q || mb_rd);
		end else begin
			fire_w = mb_wr && trig_hit(ctrl_q.trig, MB_EVT.idx);
			fire_r = mb_rd && trig_hit(ctrl_q.trig, MB_EVT.idx);
		end
		fire_w = fire_w && ctrl_q.wr_irq_allow;
		fire_r = fire_r && ctrl_q.rd_irq_allow;
	end

	// pending interrupts; a new trigger wins over the clear strobe
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			pend_w_q <= 1'b0;
			pend_r_q <= 1'b0;
		end else begin
			if (fire_w) begin
				pend_w_q <= 1'b1;
			end else if (flag_clear_strobe) begin
				pend_w_q <= 1'b0;
			end
			if (fire_r) begin
				pend_r_q <= 1'b1;
			end else if (flag_clear_strobe) begin
				pend_r_q <= 1'b0;
			end
		end
	end

	// stop gate; pending state is kept, so delivery resumes on exit
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			CPU_IRQ <= 1'b0;
		end else begin
			CPU_IRQ <= (pend_w_q || pend_r_q) && (!STOP_MODE || ctrl_q.stop_en);
		end
	end

	// Port outputs
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			PORT_ON   <= 1'b0;
			IFACE_SPI <= 1'b0;
			HOST_ADDR <= `SPC_RST_HOST_ADDR;
		end else begin
			PORT_ON   <= ctrl_q.port_on;
			IFACE_SPI <= ctrl_q.select_spi;
			HOST_ADDR <= addr_q;
		end
	end

	// Read data in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			REG_RDATA <= 8'h00;
		end else if (!REG_RD) begin
			REG_RDATA <= 8'h00;
		end else if (REG_ADDR == `SPC_OFS_HOST_ADDR) begin
			REG_RDATA <= ctrl_q.select_spi ? 8'h00 : {1'b0, addr_q};
		end else if (REG_ADDR == `SPC_OFS_CTRL) begin
			// activity shown only while port on
			REG_RDATA <= {ctrl_q.port_on, ctrl_q.select_spi,
			              active && ctrl_q.port_on, ctrl_q.stop_en,
			              ctrl_q.rd_irq_allow, ctrl_q.wr_irq_allow, ctrl_q.trig};
		end else if (REG_ADDR >= `SPC_OFS_WFLAG0 && REG_ADDR <= `SPC_OFS_WFLAG3) begin
			REG_RDATA <= flag_byte(wflags_q, REG_ADDR[1:0]);
		end else if (REG_ADDR >= `SPC_OFS_RFLAG0 && REG_ADDR <= `SPC_OFS_RFLAG3) begin
			REG_RDATA <= flag_byte(rflags_q, REG_ADDR[1:0]);
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RESET);

	property p_addr_write;
		wr_addr |=> ##1 (HOST_ADDR == $past(REG_WDATA[6:0], 2));
	endproperty
	a_addr_write: assert property (p_addr_write) else $error("host address not loaded");

	property p_addr_reserved;
		REG_RD && (REG_ADDR == `SPC_OFS_HOST_ADDR) |=> (REG_RDATA[7] == 1'b0);
	endproperty
	a_addr_reserved: assert property (p_addr_reserved) else $error("address bit 7 not zero");

	property p_spi_addr;
		REG_RD && (REG_ADDR == `SPC_OFS_HOST_ADDR) && ctrl_q.select_spi |=> (REG_RDATA == 8'h00);
	endproperty
	a_spi_addr: assert property (p_spi_addr) else $error("address visible under SPI");

	property p_boot_load;
		(boot_q == BOOT_LOAD) |=> ctrl_q.port_on ##1 PORT_ON;
	endproperty
	a_boot_load: assert property (p_boot_load) else $error("boot did not enable port");

	property p_boot_select;
		(boot_q == BOOT_LOAD) && HAS_I2C && HAS_SPI |=>
			(ctrl_q.select_spi == !$past(cs_sync_q));
	endproperty
	a_boot_select: assert property (p_boot_select) else $error("boot select wrong");

	property p_fixed_port;
		!(HAS_I2C && HAS_SPI) && wr_ctrl && (boot_q == BOOT_RUN) |=> $stable(ctrl_q.port_on);
	endproperty
	a_fixed_port: assert property (p_fixed_port) else $error("read-only port bit changed");

	property p_clear_flags;
		flag_clear_strobe && !MB_EVT.wr && !MB_EVT.rd |=> (wflags_q == 32'h0) && (rflags_q == 32'h0);
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

	property p_clear_pend;
		flag_clear_strobe && !fire_w |=> !pend_w_q;
	endproperty
	a_clear_pend: assert property (p_clear_pend) else $error("write interrupt not cleared");

	property p_wflag_set;
		mb_wr |=> wflags_q[$past(MB_EVT.idx)];
	endproperty
	a_wflag_set: assert property (p_wflag_set) else $error("write flag not set");

	property p_rflag_set;
		mb_rd |=> rflags_q[$past(MB_EVT.idx)];
	endproperty
	a_rflag_set: assert property (p_rflag_set) else $error("read flag not set");

	property p_mb15_irq;
		mb_wr && ctrl_q.wr_irq_allow && (ctrl_q.trig == `SPC_TRIG_MB15) &&
			(MB_EVT.idx == `SPC_MB15) && !STOP_MODE ##1 !STOP_MODE |=> CPU_IRQ;
	endproperty
	a_mb15_irq: assert property (p_mb15_irq) else $error("mailbox 15 interrupt missing");

	property p_stop_hold;
		STOP_MODE && !ctrl_q.stop_en |=> !CPU_IRQ;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("interrupt leaked in stop");

	property p_reserved_code;
		(ctrl_q.trig == 2'h3) && !pend_w_q && !wr_ctrl |=> !pend_w_q;
	endproperty
	a_reserved_code: assert property (p_reserved_code) else $error("code 11 raised interrupt");

	property p_xfer_irq;
		MB_EVT.xfer_end && seen_w_q && ctrl_q.wr_irq_allow &&
			(ctrl_q.trig == `SPC_TRIG_XFER) |=> pend_w_q;
	endproperty
	a_xfer_irq: assert property (p_xfer_irq) else $error("transfer interrupt missing");

	c_xfer_irq: cover property (MB_EVT.xfer_end && seen_w_q ##2 CPU_IRQ);
	c_clear: cover property (pend_w_q ##1 flag_clear_strobe ##1 !pend_w_q);
	c_spi_boot: cover property ((boot_q == BOOT_LOAD) && !cs_sync_q);
	c_stop_defer: cover property (pend_r_q && STOP_MODE ##1 !STOP_MODE ##1 CPU_IRQ);

endmodule

/* File: spc_port_ctrl_tb.sv */
`timescale 1ns/100ps
module spc_port_ctrl_tb;
	import spc_pkg::*;
	logic        mclk;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	spc_mb_evt_t mb_evt;
	logic        i2c_awake;
	logic        cs_n;
	logic        stop_mode;
	logic        port_on;
	logic        iface_spi;
	logic [6:0]  host_addr;
	logic        cpu_irq;
	logic [7:0]  v_rdata;
	logic        v_on;
	logic        v_spi;
	int          err_total;
	int          n_tests;
	logic [7:0]  v;
	logic [7:0]  c;
	logic [4:0]  ix;
	logic [1:0]  tg;
	logic        rdk;

	spc_port_ctrl spc_port_ctrl_i (.MCLK(mclk), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.MB_EVT(mb_evt), .I2C_AWAKE(i2c_awake), .CHIP_SELECT_N(cs_n),
		.STOP_MODE(stop_mode), .PORT_ON(port_on), .IFACE_SPI(iface_spi),
		.HOST_ADDR(host_addr), .CPU_IRQ(cpu_irq));
	// Single-interface variant: port-on and select must stay fixed
	spc_port_ctrl #(.HAS_I2C(1'b1), .HAS_SPI(1'b0)) spc_port_ctrl_v_i (.MCLK(mclk),
		.RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(v_rdata), .MB_EVT(mb_evt), .I2C_AWAKE(i2c_awake),
		.CHIP_SELECT_N(cs_n), .STOP_MODE(stop_mode), .PORT_ON(v_on), .IFACE_SPI(v_spi),
		.HOST_ADDR(), .CPU_IRQ());
	spc_host_model host_i (.MCLK(mclk), .MB_EVT(mb_evt), .I2C_AWAKE(i2c_awake),
		.CHIP_SELECT_N(cs_n));

	always #50 mclk = ~mclk;

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe, so look mid-cycle
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(nm, e, reg_rdata);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	function automatic logic [7:0] fofs(input logic [7:0] base, input logic [4:0] i);
		return base + 8'h03 - {6'h00, i[4:3]};
	endfunction
	function automatic logic exp_irq(input logic [1:0] t, input int s);
		case (t)
			2'h0: return s == 3;
			2'h1: return s >= 1;
			2'h2: return s >= 2;
			default: return 1'b0;
		endcase
	endfunction

	initial begin
		#1000000;
		err_total++;
		complete_run();
	end

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		stop_mode = 1'b0;
		err_total = 0;
		n_tests = 0;
		void'($urandom(65));
		repeat (8) @(posedge mclk);
		chk("reset addr", 8'h4c, {1'b0, host_addr});
		reset <= 1'b0;
		cyc(8);
		chk("boot on", 8'h01, {7'h00, port_on});
		chk("boot sel", 8'h00, {7'h00, iface_spi});
		rchk("ctrl", 8'h23, 8'h80);
		rchk("addr", 8'h22, 8'h4c);
		rchk("unmapped", 8'h30, 8'h00);
		v = 8'($urandom);
		wr(8'h22, v | 8'h80);
		rchk("addr rb", 8'h22, v & 8'h7f);
		chk("addr pin", v & 8'h7f, {1'b0, host_addr});
		host_i.pins(1'b1, 1'b1);
		rchk("i2c active", 8'h23, 8'ha0);
		host_i.pins(1'b0, 1'b1);
		for (int k = 0; k < 6; k++) begin
			ix = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom);
			rdk = (k > 1) ? 1'($urandom) : k[0];
			host_i.access(!rdk, rdk, ix, 1'b1);
			rchk("flag", fofs(rdk ? 8'h28 : 8'h24, ix), 8'h01 << ix[2:0]);
			wr(8'h23, 8'ha0);
			rchk("cleared", fofs(rdk ? 8'h28 : 8'h24, ix), 8'h00);
		end
		rchk("strobe rb", 8'h23, 8'h80);
		@(posedge mclk);
		stop_mode <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			tg = 2'(m);
			rdk = m[2];
			c = 8'h90 | (rdk ? 8'h08 : 8'h04) | {6'h00, tg};
			wr(8'h23, c);
			for (int s = 1; s < 4; s++) begin
				host_i.access(s < 3 && !rdk, s < 3 && rdk, (s == 1) ? 5'h0f : 5'h1f, s == 3);
				cyc(3);
				chk("irq", {7'h00, exp_irq(tg, s)}, {7'h00, cpu_irq});
			end
			wr(8'h23, c | 8'h20);
			cyc(3);
			chk("irq clr", 8'h00, {7'h00, cpu_irq});
		end
		wr(8'h23, 8'h85);
		host_i.access(1'b1, 1'b0, 5'h0f, 1'b1);
		cyc(4);
		chk("stop held", 8'h00, {7'h00, cpu_irq});
		@(posedge mclk);
		stop_mode <= 1'b0;
		cyc(3);
		chk("stop exit", 8'h01, {7'h00, cpu_irq});
		wr(8'h23, 8'ha1);
		host_i.access(1'b1, 1'b0, 5'h0f, 1'b1);
		cyc(3);
		chk("no allow", 8'h00, {7'h00, cpu_irq});
		host_i.pins(1'b0, 1'b0);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		cyc(10);
		chk("spi sel", 8'h01, {7'h00, iface_spi});
		chk("var sel", 8'h00, {7'h00, v_spi});
		rchk("spi ctrl", 8'h23, 8'he0);
		rchk("spi addr", 8'h22, 8'h00);
		// The port is turned off while the interface select stays on SPI
		wr(8'h23, 8'h40);
		rchk("off ctrl", 8'h23, 8'h40);
		chk("var ctrl", 8'h80, v_rdata);
		chk("var on", 8'h01, {7'h00, v_on});
		host_i.access(1'b1, 1'b0, 5'h03, 1'b1);
		rchk("off flag", fofs(8'h24, 5'h03), 8'h00);
		chk("off pin", 8'h00, {7'h00, port_on});
		complete_run();
	end
endmodule
